// [src/mmir_pkg.sv]
package mmir_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int MMIR_NUM_REGS = 10;
	localparam int MMIR_ADDR_W = 4;
	localparam int MMIR_DATA_W = 8;
	localparam logic [3:0] MMIR_OFF_HALL_EDGE = 4'h0;
	localparam logic [3:0] MMIR_OFF_PIN_EDGE = 4'h1;
	localparam logic [3:0] MMIR_OFF_NF_EDGE = 4'h2;
	localparam logic [3:0] MMIR_OFF_CTRL0 = 4'h3;
	localparam logic [3:0] MMIR_OFF_CTRL1 = 4'h4;
	localparam logic [3:0] MMIR_OFF_CTRL2 = 4'h5;
	localparam logic [3:0] MMIR_OFF_CTRL3 = 4'h6;
	localparam logic [3:0] MMIR_OFF_HALL_SUB = 4'h7;
	localparam logic [3:0] MMIR_OFF_CAP_SUB = 4'h8;
	localparam logic [3:0] MMIR_OFF_PWM_SUB = 4'h9;

	// Implemented bits, indexed by offset
	localparam logic [7:0] MMIR_REG_MASK [MMIR_NUM_REGS] = '{
		8'h7F, 8'h03, 8'hC0, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h77, 8'hFF, 8'hFF
	};
	localparam logic [7:0] MMIR_REG_RESET = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MMIR_HALL_A_SEL_LSB = 0;
	localparam int MMIR_HALL_B_SEL_LSB = 2;
	localparam int MMIR_HALL_C_SEL_LSB = 4;
	localparam int MMIR_HALL_SRC_BIT = 6;
	localparam int MMIR_PIN_SEL_LSB = 0;
	localparam int MMIR_NF_SEL_LSB = 6;
	localparam int MMIR_GATE_BIT = 0;
	localparam int MMIR_FLAG_HI = 7;
	localparam int MMIR_FLAG_LO = 4;
	localparam int MMIR_EN_HI = 3;
	localparam int MMIR_EN_LO = 0;

	// Edge select codes
	localparam logic [1:0] MMIR_EDGE_OFF = 2'h0;
	localparam logic [1:0] MMIR_EDGE_RISE = 2'h1;
	localparam logic [1:0] MMIR_EDGE_FALL = 2'h2;
	localparam logic [1:0] MMIR_EDGE_BOTH = 2'h3;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [MMIR_ADDR_W-1:0] addr;
		logic [MMIR_DATA_W-1:0] wdata;
	} mmir_bus_req_t;

	typedef struct packed {
		logic hall_a;
		logic hall_b;
		logic hall_c;
		logic ext_pin;
		logic filtered_input_pin;
	} mmir_pins_t;

	typedef struct packed {
		logic comparator;
		logic overcurrent;
		logic low_voltage;
		logic time_base;
		logic eeprom;
		logic uart;
		logic [6:3] group_n;
		logic capture_compare;
		logic capture_overflow;
		logic adc_limit;
		logic adc_done;
		logic pwm_period;
		logic [2:0] pwm_duty;
	} mmir_evt_t;

endpackage : mmir_pkg

// [src/mmir_top.sv]
// Functional notes
// - Hall edge fields at bits 5:4, 3:2, 1:0
// - Edge codes: off, rise, fall, both
// - External pin edge field at bits 1:0
// - Filtered input edge field at bits 7:6
// - Unimplemented bits read zero, ignore writes
// - Global gate bit blocks all interrupts
// - Enable passes source; flag shows pending request
// - Control 0: comparator, pin, hall group pairs
// - Control 1: overcurrent, low voltage, group1, filtered
// - Control 2: groups 5..2 flags and enables
// - Control 3: time base, group6, eeprom, uart
// - Hall sub flags 6:4, enables 2:0
// - Capture and converter sub flag/enable pairs
// - PWM period and duty sub flag/enable pairs
// - Sub flags cleared only by software writes
// - Hall source select bit stored, forwarded out
// - Flags set even when source disabled
// - Core accept clears gate; flags still record
`timescale 1ns/100ps

// ------------------------------------------------------------
// Synchroniser and selectable edge detector
// ------------------------------------------------------------
module mmir_edge_det (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Pin and edge select
	input wire logic pin,
	input wire logic [1:0] sel,
	// Detected edge
	output logic hit
);
	logic sync1_q;
	logic sync2_q;
	logic last_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			sync1_q <= pin;
			sync2_q <= sync1_q;
			last_q <= sync2_q;
		end
	end

	// Bit 0 of the code picks rising, bit 1 falling; zero picks neither
	assign hit = (sel[0] & sync2_q & ~last_q) | (sel[1] & ~sync2_q & last_q);

endmodule : mmir_edge_det

// ------------------------------------------------------------
// Interrupt enable and flag registers
// ------------------------------------------------------------
module mmir_top (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire mmir_pkg::mmir_bus_req_t bus,
	output logic [7:0] rdata,
	// Edge-triggered inputs from pins and filters
	input wire mmir_pkg::mmir_pins_t pins,
	// Event pulses from peripherals
	input wire mmir_pkg::mmir_evt_t evt,
	// Core side
	input wire logic irq_ack,
	output logic irq_req,
	// Hall input logic
	output logic hall_source_sel
);
	logic [7:0] regs_q [mmir_pkg::MMIR_NUM_REGS];
	logic [7:0] regs_next [mmir_pkg::MMIR_NUM_REGS];
	logic [7:0] set_vec [mmir_pkg::MMIR_NUM_REGS];
	logic hall_a_hit;
	logic hall_b_hit;
	logic hall_c_hit;
	logic ext_hit;
	logic nf_hit;
	logic group0_any;
	logic group1_any;
	logic group2_any;
	logic pending;
	logic gate;
	logic [7:0] c0;
	logic [7:0] c1;
	logic [7:0] c2;
	logic [7:0] c3;

	assign c0 = regs_q[mmir_pkg::MMIR_OFF_CTRL0];
	assign c1 = regs_q[mmir_pkg::MMIR_OFF_CTRL1];
	assign c2 = regs_q[mmir_pkg::MMIR_OFF_CTRL2];
	assign c3 = regs_q[mmir_pkg::MMIR_OFF_CTRL3];
	assign gate = c0[mmir_pkg::MMIR_GATE_BIT];

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	mmir_edge_det u_hall_a (
		.clock(clock),
		.rst_n(rst_n),
		.pin(pins.hall_a),
		.sel(regs_q[mmir_pkg::MMIR_OFF_HALL_EDGE][mmir_pkg::MMIR_HALL_A_SEL_LSB +: 2]),
		.hit(hall_a_hit)
	);
	mmir_edge_det u_hall_b (
		.clock(clock),
		.rst_n(rst_n),
		.pin(pins.hall_b),
		.sel(regs_q[mmir_pkg::MMIR_OFF_HALL_EDGE][mmir_pkg::MMIR_HALL_B_SEL_LSB +: 2]),
		.hit(hall_b_hit)
	);
	mmir_edge_det u_hall_c (
		.clock(clock),
		.rst_n(rst_n),
		.pin(pins.hall_c),
		.sel(regs_q[mmir_pkg::MMIR_OFF_HALL_EDGE][mmir_pkg::MMIR_HALL_C_SEL_LSB +: 2]),
		.hit(hall_c_hit)
	);
	mmir_edge_det u_ext (
		.clock(clock),
		.rst_n(rst_n),
		.pin(pins.ext_pin),
		.sel(regs_q[mmir_pkg::MMIR_OFF_PIN_EDGE][mmir_pkg::MMIR_PIN_SEL_LSB +: 2]),
		.hit(ext_hit)
	);
	mmir_edge_det u_nf (
		.clock(clock),
		.rst_n(rst_n),
		.pin(pins.filtered_input_pin),
		.sel(regs_q[mmir_pkg::MMIR_OFF_NF_EDGE][mmir_pkg::MMIR_NF_SEL_LSB +: 2]),
		.hit(nf_hit)
	);

	// ------------------------------------------------------------
	// Group summaries and pending request
	// ------------------------------------------------------------
	always_comb begin
		group0_any = |(regs_q[mmir_pkg::MMIR_OFF_HALL_SUB][7:4]
			& regs_q[mmir_pkg::MMIR_OFF_HALL_SUB][3:0]);
		group1_any = |(regs_q[mmir_pkg::MMIR_OFF_CAP_SUB][7:4]
			& regs_q[mmir_pkg::MMIR_OFF_CAP_SUB][3:0]);
		group2_any = |(regs_q[mmir_pkg::MMIR_OFF_PWM_SUB][7:4]
			& regs_q[mmir_pkg::MMIR_OFF_PWM_SUB][3:0]);
		pending = |(c0[6:4] & c0[3:1]) | |(c1[7:4] & c1[3:0])
			| |(c2[7:4] & c2[3:0]) | |(c3[7:4] & c3[3:0]);
	end

	// ------------------------------------------------------------
	// Hardware set vectors
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < mmir_pkg::MMIR_NUM_REGS; i++) begin
			set_vec[i] = mmir_pkg::MMIR_REG_RESET;
		end
		set_vec[mmir_pkg::MMIR_OFF_CTRL0][6:4] = {evt.comparator, ext_hit, group0_any};
		set_vec[mmir_pkg::MMIR_OFF_CTRL1][7:4] =
			{evt.overcurrent, evt.low_voltage, group1_any, nf_hit};
		set_vec[mmir_pkg::MMIR_OFF_CTRL2][7:4] =
			{evt.group_n[5], evt.group_n[4], evt.group_n[3], group2_any};
		set_vec[mmir_pkg::MMIR_OFF_CTRL3][7:4] =
			{evt.time_base, evt.group_n[6], evt.eeprom, evt.uart};
		set_vec[mmir_pkg::MMIR_OFF_HALL_SUB][6:4] = {hall_c_hit, hall_b_hit, hall_a_hit};
		set_vec[mmir_pkg::MMIR_OFF_CAP_SUB][7:4] = {evt.capture_compare, evt.capture_overflow,
			evt.adc_limit, evt.adc_done};
		set_vec[mmir_pkg::MMIR_OFF_PWM_SUB][7:4] = {evt.pwm_period, evt.pwm_duty};
	end

	// ------------------------------------------------------------
	// Register next state
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < mmir_pkg::MMIR_NUM_REGS; i++) begin
			// Only software writes clear a flag; a same-cycle event wins
			regs_next[i] = (bus.wr && bus.addr == 4'(i))
				? (bus.wdata & mmir_pkg::MMIR_REG_MASK[i]) : regs_q[i];
			regs_next[i] = regs_next[i] | (set_vec[i] & mmir_pkg::MMIR_REG_MASK[i]);
		end
		if (irq_ack) begin
			regs_next[mmir_pkg::MMIR_OFF_CTRL0][mmir_pkg::MMIR_GATE_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < mmir_pkg::MMIR_NUM_REGS; i++) begin
				regs_q[i] <= mmir_pkg::MMIR_REG_RESET;
			end
		end else begin
			for (int i = 0; i < mmir_pkg::MMIR_NUM_REGS; i++) begin
				regs_q[i] <= regs_next[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (bus.rd && bus.addr < 4'(mmir_pkg::MMIR_NUM_REGS)) begin
			rdata <= regs_q[bus.addr];
		end else begin
			rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Core request
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= gate & pending & ~irq_ack;
		end
	end

	// ------------------------------------------------------------
	// Hall source select
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hall_source_sel <= 1'b0;
		end else begin
			hall_source_sel <= regs_q[mmir_pkg::MMIR_OFF_HALL_EDGE][mmir_pkg::MMIR_HALL_SRC_BIT];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	unimp_read_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		bus.rd && bus.addr == mmir_pkg::MMIR_OFF_PIN_EDGE |=> rdata[7:2] == 6'h00)
		else $error("unimplemented bits read nonzero");

	gate_blocks_a: assert property (@(posedge clock) disable iff (!rst_n)
		!gate |=> !irq_req)
		else $error("request raised with gate closed");

	enabled_req_a: assert property (@(posedge clock) disable iff (!rst_n)
		gate && c3[7] && c3[3] && !irq_ack |=> irq_req)
		else $error("enabled pending source not requested");

	ack_clears_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		irq_ack |=> !gate && !irq_req)
		else $error("gate not cleared on accept");

	flag_when_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		evt.comparator && !c0[3] |=> c0[6])
		else $error("disabled source flag not set");

	sub_flag_held_a: assert property (@(posedge clock) disable iff (!rst_n)
		regs_q[mmir_pkg::MMIR_OFF_PWM_SUB][7]
		&& !(bus.wr && bus.addr == mmir_pkg::MMIR_OFF_PWM_SUB)
		|=> regs_q[mmir_pkg::MMIR_OFF_PWM_SUB][7])
		else $error("sub flag dropped without write");

	group_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		group0_any && !(bus.wr && bus.addr == mmir_pkg::MMIR_OFF_CTRL0) |=> c0[4])
		else $error("hall group flag not set");

	pin_rise_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(pins.ext_pin)
		&& regs_q[mmir_pkg::MMIR_OFF_PIN_EDGE][1:0] == mmir_pkg::MMIR_EDGE_RISE
		&& !bus.wr ##1 !bus.wr[*2] |=> c0[5])
		else $error("pin rising edge not flagged");

	rdata_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
		!bus.rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");

	high_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
		bus.rd && bus.addr > mmir_pkg::MMIR_OFF_PWM_SUB |=> rdata == 8'h00)
		else $error("read beyond register set nonzero");

	read_data_a: assert property (@(posedge clock) disable iff (!rst_n)
		bus.rd && bus.addr == mmir_pkg::MMIR_OFF_CTRL3 |=> rdata == $past(c3))
		else $error("read data differs from register");

	pin_mask_a: assert property (@(posedge clock) disable iff (!rst_n)
		regs_q[mmir_pkg::MMIR_OFF_PIN_EDGE][7:2] == 6'h00)
		else $error("pin edge register spare bits set");

	nf_mask_a: assert property (@(posedge clock) disable iff (!rst_n)
		regs_q[mmir_pkg::MMIR_OFF_NF_EDGE][5:0] == 6'h00)
		else $error("filtered edge register spare bits set");

	src_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> hall_source_sel == $past(regs_q[mmir_pkg::MMIR_OFF_HALL_EDGE][6]))
		else $error("hall source select not forwarded");

	uart_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		evt.uart |=> c3[4])
		else $error("uart flag not set");

	overcurrent_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		evt.overcurrent |=> c1[7])
		else $error("overcurrent flag not set");

	group5_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		evt.group_n[5] |=> c2[7])
		else $error("group 5 flag not set");

	capture_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		evt.capture_compare |=> regs_q[mmir_pkg::MMIR_OFF_CAP_SUB][7])
		else $error("capture compare flag not set");

	duty_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		evt.pwm_duty[0] |=> regs_q[mmir_pkg::MMIR_OFF_PWM_SUB][4])
		else $error("duty match flag not set");

	nf_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
		nf_hit |=> c1[4])
		else $error("filtered input flag not set");

	req_pending_a: assert property (@(posedge clock) disable iff (!rst_n)
		!pending |=> !irq_req)
		else $error("request raised with nothing pending");

	hall_sub_held_a: assert property (@(posedge clock) disable iff (!rst_n)
		regs_q[mmir_pkg::MMIR_OFF_HALL_SUB][4]
		&& !(bus.wr && bus.addr == mmir_pkg::MMIR_OFF_HALL_SUB)
		|=> regs_q[mmir_pkg::MMIR_OFF_HALL_SUB][4])
		else $error("hall sub flag dropped without write");

	irq_taken_c: cover property (@(posedge clock) disable iff (!rst_n) irq_req ##1 irq_ack);
	hall_group_c: cover property (@(posedge clock) disable iff (!rst_n) hall_a_hit ##[1:3] c0[4]);
	both_edge_c: cover property (@(posedge clock) disable iff (!rst_n)
		regs_q[mmir_pkg::MMIR_OFF_NF_EDGE][7:6] == mmir_pkg::MMIR_EDGE_BOTH && nf_hit);
	group_req_c: cover property (@(posedge clock) disable iff (!rst_n)
		group1_any && c1[1] && irq_req);
	sub_clear_c: cover property (@(posedge clock) disable iff (!rst_n)
		$fell(regs_q[mmir_pkg::MMIR_OFF_CAP_SUB][4]));

endmodule : mmir_top

// [verification/mmir_core_model.sv]
`timescale 1ns/100ps

// ------------------------------------------------------------
// Core side: accepts a standing request after a set delay
// ------------------------------------------------------------
module mmir_core_model #(
	parameter int LAT = 2
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Request and acceptance
	input wire logic irq_req,
	input wire logic ack_en,
	output logic irq_ack
);
	int unsigned wait_cnt;

	// One-cycle accept pulse; flags are left to software
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_ack <= 1'b0;
			wait_cnt <= 0;
		end else if (irq_ack) begin
			irq_ack <= 1'b0;
			wait_cnt <= 0;
		end else if (ack_en && irq_req) begin
			if (wait_cnt == LAT) begin
				irq_ack <= 1'b1;
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end else begin
			wait_cnt <= 0;
		end
	end
endmodule : mmir_core_model

// [verification/mmir_top_test.sv]
`timescale 1ns/100ps

module mmir_top_test;
	logic clock;
	logic rst_n;
	mmir_pkg::mmir_bus_req_t bus;
	logic [7:0] rdata;
	logic [4:0] pin_v;
	logic [17:0] evt_v;
	logic irq_ack;
	logic irq_req;
	logic hall_source_sel;
	logic ack_en;
	int errors = 0;
	int checks_done = 0;
	int i;
	int p;
	int c;
	int k;
	logic [31:0] r;
	logic [3:0] fa;
	logic [2:0] fb;
	logic [7:0] m [16];
	logic [7:0] msk [16] = '{8'h7F, 8'h03, 8'hC0, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h77,
		8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// Event bit to {register, flag bit}
	logic [7:0] tbl [18] = '{8'h94, 8'h95, 8'h96, 8'h97, 8'h84, 8'h85, 8'h86, 8'h87, 8'h55,
		8'h56, 8'h57, 8'h66, 8'h64, 8'h65, 8'h67, 8'h46, 8'h47, 8'h36};
	// Pin to {select reg, select lsb, flag reg, flag bit}
	logic [15:0] ptab [5] = '{16'h0074, 16'h0275, 16'h0476, 16'h1035, 16'h2644};

	mmir_top mmir_top_inst (
		.clock(clock),
		.rst_n(rst_n),
		.bus(bus),
		.rdata(rdata),
		.pins(mmir_pkg::mmir_pins_t'(pin_v)),
		.evt(mmir_pkg::mmir_evt_t'(evt_v)),
		.irq_ack(irq_ack),
		.irq_req(irq_req),
		.hall_source_sel(hall_source_sel)
	);

	mmir_core_model #(.LAT(3)) mmir_core_model_inst (
		.clock(clock),
		.rst_n(rst_n),
		.irq_req(irq_req),
		.ack_en(ack_en),
		.irq_ack(irq_ack)
	);

	// ------------------------------------------------------------
	// Reference model and helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction : lfsr

	function automatic void sync();
		if ((m[7][6:4] & m[7][2:0]) != 3'h0) m[3][4] = 1'b1;
		if ((m[8][7:4] & m[8][3:0]) != 4'h0) m[4][5] = 1'b1;
		if ((m[9][7:4] & m[9][3:0]) != 4'h0) m[5][4] = 1'b1;
	endfunction : sync

	function automatic logic exp_irq();
		return m[3][0] && (((m[3][6:4] & m[3][3:1]) != 3'h0) || ((m[4][7:4] & m[4][3:0]) != 4'h0)
			|| ((m[5][7:4] & m[5][3:0]) != 4'h0) || ((m[6][7:4] & m[6][3:0]) != 4'h0));
	endfunction : exp_irq

	task automatic wrap_up;
		if (errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		bus <= '0;
		m[a] = d & msk[a];
		sync();
		@(posedge clock);
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		bus <= '0;
		#1;
		chk(rdata, m[a]);
		chk({7'h00, irq_req}, {7'h00, exp_irq()});
	endtask : rd

	task automatic pulse(input int n);
		logic [3:0] a;
		@(posedge clock);
		evt_v <= 18'h00001 << n;
		@(posedge clock);
		evt_v <= '0;
		a = tbl[n][7:4];
		m[a][tbl[n][2:0]] = 1'b1;
		sync();
		@(posedge clock);
	endtask : pulse

	task automatic pin_set(input int n, input logic v);
		@(posedge clock);
		pin_v[4 - n] <= v;
		repeat (5) @(posedge clock);
	endtask : pin_set

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		bus = '0;
		pin_v = 5'h00;
		evt_v = 18'h00000;
		ack_en = 1'b0;
		r = 32'h85A9BFB7;
		foreach (m[j]) m[j] = 8'h00;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		for (i = 0; i < 16; i++) rd(4'(i));
		for (i = 0; i < 24; i++) begin
			r = lfsr(r);
			wr(r[3:0], r[11:4]);
			rd(r[3:0]);
			chk({7'h00, hall_source_sel}, {7'h00, m[0][6]});
		end
		wr(4'h0, 8'h40);
		rd(4'h0);
		chk({7'h00, hall_source_sel}, {7'h00, m[0][6]});
		for (i = 9; i >= 0; i--) wr(4'(i), 8'h00);
		for (i = 0; i < 18; i++) begin
			pulse(i);
			rd(tbl[i][7:4]);
			wr(tbl[i][7:4], 8'h00);
		end
		for (p = 0; p < 5; p++) begin
			fa = ptab[p][7:4];
			fb = ptab[p][2:0];
			for (c = 0; c < 4; c++) begin
				wr(ptab[p][15:12], 8'(c << ptab[p][11:8]));
				pin_set(p, 1'b1);
				if (c[0]) m[fa][fb] = 1'b1;
				rd(fa);
				wr(fa, 8'h00);
				pin_set(p, 1'b0);
				if (c[1]) m[fa][fb] = 1'b1;
				rd(fa);
				wr(fa, 8'h00);
			end
		end
		wr(4'h8, 8'h01);
		pulse(4);
		rd(4'h4);
		wr(4'h4, m[4] | 8'h02);
		rd(4'h4);
		wr(4'h3, 8'h01);
		rd(4'h3);
		@(posedge clock);
		ack_en <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clock);
			#1;
			if (irq_ack === 1'b1) break;
		end
		if (k == 40) begin
			errors++;
			wrap_up();
		end
		m[3][0] = 1'b0;
		pulse(17);
		rd(4'h3);
		rd(4'h8);
		wr(4'h8, 8'h01);
		wr(4'h4, 8'h02);
		rd(4'h4);
		wrap_up();
	end
endmodule : mmir_top_test
